// ### src/ffop_consts.vh
`ifndef FFOP_CONSTS_VH
`define FFOP_CONSTS_VH

// bus width codes, captured from the width straps at master reset
`define FFOP_BUS_X36 2'h0
`define FFOP_BUS_X18 2'h1
`define FFOP_BUS_X9 2'h2

// offset register slots, in programming and readback order
`define FFOP_SLOT_EMPTY_LO 3'h0
`define FFOP_SLOT_EMPTY_HI 3'h1
`define FFOP_SLOT_FULL_LO 3'h2
`define FFOP_SLOT_FULL_HI 3'h3
`define FFOP_SLOT_X9_LAST 3'h5

// widest offset register and the serial bit counter
`define FFOP_OFFSET_MAX_W 15
`define FFOP_BITCNT_W 5

// x9 bus: bits of one offset carried by the low byte
`define FFOP_BYTE_W 8

// edges from completed offset load to valid flag
`define FFOP_FLAG_DELAY 2

// offset values used until first programming
`define FFOP_DEF_EMPTY_OFFSET 15'h007F
`define FFOP_DEF_FULL_OFFSET 15'h007F

`endif

// ### src/ffop_offset_prog.v
`include "ffop_consts.vh"

module ffop_offset_prog #(
  parameter OFFSET_W = 15
) (
  // clock and resets
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire partial_rst_i,
  // straps, captured while master reset is held
  input wire serial_mode_strap_i,
  input wire [1:0] in_width_strap_i,
  input wire [1:0] out_width_strap_i,
  // host strobes, all active low
  input wire offset_load_select_n_i,
  input wire serial_shift_enable_n_i,
  input wire push_enable_n_i,
  input wire pop_enable_n_i,
  // data in
  input wire serial_offset_in_i,
  input wire [35:0] input_word_i,
  input wire [35:0] fifo_read_data_i,
  // memory side strobes
  output wire fifo_write_o,
  output wire fifo_read_o,
  // data out and thresholds
  output wire [35:0] output_word_o,
  output wire [OFFSET_W-1:0] almost_empty_threshold_o,
  output wire [OFFSET_W-1:0] almost_full_threshold_o,
  // flag validity
  output wire almost_empty_flag_valid_o,
  output wire almost_full_flag_valid_o
);

  localparam [`FFOP_BITCNT_W-1:0] LAST_BIT = 2 * OFFSET_W - 1;
  localparam [`FFOP_BITCNT_W-1:0] WIDTH_BITS = OFFSET_W;

  reg serial_mode_reg;
  reg [1:0] in_width_reg;
  reg [1:0] out_width_reg;
  reg [OFFSET_W-1:0] empty_off_reg;
  reg [OFFSET_W-1:0] full_off_reg;
  reg [`FFOP_BITCNT_W-1:0] bit_idx_reg;
  reg [2:0] wr_slot_reg;
  reg [2:0] rd_slot_reg;
  reg [35:0] out_word_reg;
  reg ae_ok_reg;
  reg af_ok_reg;
  reg [`FFOP_FLAG_DELAY-1:0] ae_dly_reg;
  reg [`FFOP_FLAG_DELAY-1:0] af_dly_reg;

  wire load_low = ~offset_load_select_n_i;
  wire serial_shift = serial_mode_reg & load_low & ~serial_shift_enable_n_i;
  wire par_write = ~serial_mode_reg & load_low & ~push_enable_n_i;
  wire off_read = load_low & ~pop_enable_n_i;
  wire [`FFOP_BITCNT_W-1:0] full_idx = bit_idx_reg - WIDTH_BITS;

  // memory accesses only while load is high
  assign fifo_write_o = offset_load_select_n_i & ~push_enable_n_i;
  assign fifo_read_o = offset_load_select_n_i & ~pop_enable_n_i;

  // next slot in the sequence for a given bus width, wrapping to empty lo
  function [2:0] ffop_next_slot;
    input [2:0] slot;
    input [1:0] width;
    begin
      case (width)
        `FFOP_BUS_X36: ffop_next_slot = (slot == `FFOP_SLOT_EMPTY_LO) ? `FFOP_SLOT_FULL_LO : `FFOP_SLOT_EMPTY_LO;
        `FFOP_BUS_X18: ffop_next_slot = (slot == `FFOP_SLOT_FULL_HI) ? `FFOP_SLOT_EMPTY_LO : slot + 3'h1;
        default: ffop_next_slot = (slot == `FFOP_SLOT_X9_LAST) ? `FFOP_SLOT_EMPTY_LO : slot + 3'h1;
      endcase
    end
  endfunction

  // true when the slot completes its register for that width
  function ffop_slot_last;
    input [2:0] slot;
    input [1:0] width;
    input full_reg;
    begin
      if (width == `FFOP_BUS_X36)
        ffop_slot_last = (slot == (full_reg ? `FFOP_SLOT_FULL_LO : `FFOP_SLOT_EMPTY_LO));
      else
        ffop_slot_last = (slot == (full_reg ? `FFOP_SLOT_FULL_HI : `FFOP_SLOT_EMPTY_HI));
    end
  endfunction

  // merge one bus word into an offset; x9 splits bytes, wider buses carry it whole
  function [OFFSET_W-1:0] ffop_merge;
    input [OFFSET_W-1:0] old;
    input [35:0] word;
    input [1:0] width;
    input hi;
    reg [`FFOP_OFFSET_MAX_W-1:0] wide;
    begin
      wide = {{(`FFOP_OFFSET_MAX_W-OFFSET_W){1'b0}}, old};
      if (width != `FFOP_BUS_X9) begin
        if (!hi)
          wide = word[`FFOP_OFFSET_MAX_W-1:0];
      end else if (hi) begin
        wide[`FFOP_OFFSET_MAX_W-1:`FFOP_BYTE_W] = word[`FFOP_OFFSET_MAX_W-`FFOP_BYTE_W-1:0];
      end else begin
        wide[`FFOP_BYTE_W-1:0] = word[`FFOP_BYTE_W-1:0];
      end
      ffop_merge = wide[OFFSET_W-1:0];
    end
  endfunction

  // output word for a readback slot; slots past full hi read zero
  function [35:0] ffop_read_word;
    input [2:0] slot;
    input [1:0] width;
    input [OFFSET_W-1:0] e;
    input [OFFSET_W-1:0] f;
    reg [`FFOP_OFFSET_MAX_W-1:0] v;
    reg hi;
    begin
      v = (slot[1] && slot <= `FFOP_SLOT_FULL_HI) ? {{(`FFOP_OFFSET_MAX_W-OFFSET_W){1'b0}}, f}
                                                 : {{(`FFOP_OFFSET_MAX_W-OFFSET_W){1'b0}}, e};
      hi = slot[0];
      ffop_read_word = 36'h0;
      if (slot > `FFOP_SLOT_FULL_HI)
        ffop_read_word = 36'h0;
      else if (width != `FFOP_BUS_X9)
        ffop_read_word[`FFOP_OFFSET_MAX_W-1:0] = hi ? {`FFOP_OFFSET_MAX_W{1'b0}} : v;
      else if (hi)
        ffop_read_word[`FFOP_OFFSET_MAX_W-`FFOP_BYTE_W-1:0] = v[`FFOP_OFFSET_MAX_W-1:`FFOP_BYTE_W];
      else
        ffop_read_word[`FFOP_BYTE_W-1:0] = v[`FFOP_BYTE_W-1:0];
    end
  endfunction

  // straps are sampled only while master reset is held, so mode cannot change later
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      serial_mode_reg <= serial_mode_strap_i;
      in_width_reg <= in_width_strap_i;
      out_width_reg <= out_width_strap_i;
    end
  end

  // offset registers, write pointer and serial bit counter
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      empty_off_reg <= `FFOP_DEF_EMPTY_OFFSET;
      full_off_reg <= `FFOP_DEF_FULL_OFFSET;
      bit_idx_reg <= {`FFOP_BITCNT_W{1'b0}};
      wr_slot_reg <= `FFOP_SLOT_EMPTY_LO;
      ae_ok_reg <= 1'b1;
      af_ok_reg <= 1'b1;
    end else if (serial_shift) begin
      // one bit per edge; any pause just holds the counter
      if (bit_idx_reg < WIDTH_BITS)
        empty_off_reg[bit_idx_reg[3:0]] <= serial_offset_in_i;
      else
        full_off_reg[full_idx[3:0]] <= serial_offset_in_i;
      if (bit_idx_reg == LAST_BIT) begin
        bit_idx_reg <= {`FFOP_BITCNT_W{1'b0}};
        ae_ok_reg <= 1'b1;
        af_ok_reg <= 1'b1;
      end else begin
        bit_idx_reg <= bit_idx_reg + 5'h01;
        if (bit_idx_reg == {`FFOP_BITCNT_W{1'b0}}) begin
          // a fresh pass makes both flags untrustworthy until it ends
          ae_ok_reg <= 1'b0;
          af_ok_reg <= 1'b0;
        end
      end
    end else if (par_write) begin
      // partial reset is not decoded here, so the pointer survives it
      wr_slot_reg <= ffop_next_slot(wr_slot_reg, in_width_reg);
      if (wr_slot_reg <= `FFOP_SLOT_EMPTY_HI) begin
        empty_off_reg <= ffop_merge(empty_off_reg, input_word_i, in_width_reg, wr_slot_reg[0]);
        ae_ok_reg <= ffop_slot_last(wr_slot_reg, in_width_reg, 1'b0);
      end else if (wr_slot_reg <= `FFOP_SLOT_FULL_HI) begin
        full_off_reg <= ffop_merge(full_off_reg, input_word_i, in_width_reg, wr_slot_reg[0]);
        af_ok_reg <= ffop_slot_last(wr_slot_reg, in_width_reg, 1'b1);
      end
    end
  end

  // readback pointer and output word; independent of the write pointer
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_slot_reg <= `FFOP_SLOT_EMPTY_LO;
      out_word_reg <= 36'h0;
    end else if (off_read) begin
      out_word_reg <= ffop_read_word(rd_slot_reg, out_width_reg, empty_off_reg, full_off_reg);
      rd_slot_reg <= ffop_next_slot(rd_slot_reg, out_width_reg);
    end else if (fifo_read_o) begin
      out_word_reg <= fifo_read_data_i;
    end
  end

  // flag validity trails completion by two edges on serial, x18 and x9 loads, matching the flag synchronisers
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ae_dly_reg <= {`FFOP_FLAG_DELAY{1'b1}};
      af_dly_reg <= {`FFOP_FLAG_DELAY{1'b1}};
    end else begin
      ae_dly_reg <= {ae_dly_reg[0], ae_ok_reg};
      af_dly_reg <= {af_dly_reg[0], af_ok_reg};
    end
  end

  assign output_word_o = out_word_reg;
  assign almost_empty_threshold_o = empty_off_reg;
  assign almost_full_threshold_o = full_off_reg;
  // every stage must agree, so a one-cycle dip of ok restarts the full two-edge wait
  assign almost_empty_flag_valid_o = (&ae_dly_reg) & ae_ok_reg;
  assign almost_full_flag_valid_o = (&af_dly_reg) & af_ok_reg;

endmodule

// ### sim/ffop_mem_model.sv
module ffop_mem_model (
  // clock
  input wire clk_sys_i,
  // memory strobes and data from the block
  input wire write_i,
  input wire read_i,
  input wire [35:0] wdata_i,
  // word offered back to the block
  output logic [35:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] mem_reg = 36'h0;
  always @(posedge clk_sys_i) begin
    if (write_i) begin
      mem_reg <= wdata_i;
    end
  end
  // unselected data is inverted so a stale word never passes for a fresh one
  assign rdata_o = read_i ? mem_reg : ~mem_reg;
endmodule

// ### sim/ffop_offset_prog_asserts.sv
`include "ffop_consts.vh"
module ffop_offset_prog_asserts #(
  parameter OFFSET_W = 15
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire offset_load_select_n_i,
  input wire serial_shift_enable_n_i,
  input wire push_enable_n_i,
  input wire pop_enable_n_i,
  input wire [35:0] fifo_read_data_i,
  input wire fifo_write_o,
  input wire fifo_read_o,
  input wire [35:0] output_word_o,
  input wire [OFFSET_W-1:0] almost_empty_threshold_o,
  input wire [OFFSET_W-1:0] almost_full_threshold_o,
  input wire almost_empty_flag_valid_o,
  input wire almost_full_flag_valid_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_WR_ROUTE: assert property (fifo_write_o == (offset_load_select_n_i && !push_enable_n_i))
    else $error("bad memory write strobe");
  AST_RD_ROUTE: assert property (fifo_read_o == (offset_load_select_n_i && !pop_enable_n_i))
    else $error("bad memory read strobe");
  AST_MEM_READ: assert property (offset_load_select_n_i && !pop_enable_n_i |=>
    output_word_o == $past(fifo_read_data_i)) else $error("memory word not on output");
  AST_OFS_READ: assert property (!offset_load_select_n_i && !pop_enable_n_i |=>
    output_word_o[35:OFFSET_W] == '0) else $error("offset word has stray bits");
  AST_NO_SHIFT: assert property (!offset_load_select_n_i && serial_shift_enable_n_i && push_enable_n_i |=>
    $stable(almost_empty_threshold_o) && $stable(almost_full_threshold_o)) else $error("offset changed idle");
  AST_MEM_HOLD: assert property (offset_load_select_n_i |=>
    $stable(almost_empty_threshold_o) && $stable(almost_full_threshold_o)) else $error("offset changed on memory");
  AST_FULL_SETTLE: assert property ($rose(almost_full_flag_valid_o) |-> !$past(almost_full_flag_valid_o, 2))
    else $error("full flag valid too early");
  AST_EMPTY_SETTLE: assert property ($rose(almost_empty_flag_valid_o) |-> !$past(almost_empty_flag_valid_o, 2))
    else $error("empty flag valid too early");
  AST_RST_DEFAULT: assert property (disable iff (1'b0) sys_rst_i |=> output_word_o == 36'h0 &&
    almost_empty_threshold_o == `FFOP_DEF_EMPTY_OFFSET && almost_full_threshold_o == `FFOP_DEF_FULL_OFFSET)
    else $error("reset values wrong");
  cover property (!offset_load_select_n_i && !serial_shift_enable_n_i);
  cover property (!offset_load_select_n_i && !pop_enable_n_i);
  cover property ($rose(almost_full_flag_valid_o));
endmodule
bind ffop_offset_prog ffop_offset_prog_asserts #(.OFFSET_W(OFFSET_W)) u_chk (.*);

// ### sim/tb_fifo_flag_offset_programming.sv
`include "ffop_consts.vh"
module tb_fifo_flag_offset_programming;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] IDL = 4'hF, OWR = 4'h5, ORD = 4'h6, SHF = 4'h3, MWR = 4'hD, MRD = 4'hE, PSE = 4'h7;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, partial_rst_i = 1'b0, serial_mode_strap_i = 1'b0;
  logic [1:0] in_width_strap_i = 2'h0, out_width_strap_i = 2'h0;
  logic offset_load_select_n_i = 1'b1, serial_shift_enable_n_i = 1'b1, push_enable_n_i = 1'b1;
  logic pop_enable_n_i = 1'b1, serial_offset_in_i = 1'b0;
  logic [35:0] input_word_i = 36'h0, fifo_read_data_i, output_word_o;
  logic fifo_write_o, fifo_read_o, almost_empty_flag_valid_o, almost_full_flag_valid_o;
  logic [14:0] almost_empty_threshold_o, almost_full_threshold_o;
  logic [35:0] exp_q[$];
  int errors = 0, total_checks = 0;
  ffop_offset_prog #(.OFFSET_W(15)) uut (.*);
  ffop_mem_model mem (.clk_sys_i(clk_sys_i), .write_i(fifo_write_o), .read_i(fifo_read_o),
    .wdata_i(input_word_i), .rdata_o(fifo_read_data_i));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // strobes packed as load, shift, push, pop; all active low
  task automatic step(input logic [3:0] c, input logic [35:0] d = 36'h0, input logic b = 1'b0);
    @(posedge clk_sys_i);
    {offset_load_select_n_i, serial_shift_enable_n_i, push_enable_n_i, pop_enable_n_i} <= c;
    input_word_i <= d;
    serial_offset_in_i <= b;
  endtask
  task automatic rst_to(input logic s, input logic [1:0] w);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    serial_mode_strap_i <= s;
    in_width_strap_i <= w;
    out_width_strap_i <= w;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
  endtask
  task automatic read_back(input string n);
    int k;
    k = exp_q.size();
    step(ORD);
    for (int i = 0; i < k; i++) begin
      step(i == k - 1 ? IDL : ORD);
      #1 chk(n, exp_q[i], output_word_o);
    end
  endtask
  task automatic test_par36;
    rst_to(1'b0, `FFOP_BUS_X36);
    step(OWR, 36'hFFFFF0123);
    step(OWR, 36'h456);
    step(OWR, 36'h7ABC);
    step(MWR, 36'hA5A5A5A5A);
    step(IDL);
    #1 chk("ae36", 36'h7ABC, almost_empty_threshold_o);
    chk("af36", 36'h456, almost_full_threshold_o);
    step(ORD);
    step(MRD);
    #1 chk("rd_e", 36'h7ABC, output_word_o);
    step(ORD);
    #1 chk("mem", 36'hA5A5A5A5A, output_word_o);
    step(IDL);
    #1 chk("rd_f", 36'h456, output_word_o);
    chk("v36", 36'h3, {almost_empty_flag_valid_o, almost_full_flag_valid_o});
    exp_q = '{36'h7ABC, 36'h456};
    read_back("wrap36");
  endtask
  task automatic test_ser9;
    logic [29:0] v;
    v = {15'h51A7, 15'h2B3C};
    rst_to(1'b1, `FFOP_BUS_X9);
    step(OWR, 36'h7FFF);
    step(PSE);
    #1 chk("ser_par", 36'h7F, almost_empty_threshold_o);
    for (int i = 0; i < 30; i++) begin
      if (i == 9) begin
        step(PSE);
        step(4'hB);
        step(MWR, 36'h5);
      end
      step(SHF, 36'h0, v[i]);
    end
    step(IDL);
    #1 chk("afv0", 36'h0, almost_full_flag_valid_o);
    step(IDL);
    #1 chk("aev1", 36'h0, almost_empty_flag_valid_o);
    step(IDL);
    #1 chk("v2", 36'h3, {almost_empty_flag_valid_o, almost_full_flag_valid_o});
    chk("ae9", 36'h2B3C, almost_empty_threshold_o);
    chk("af9", 36'h51A7, almost_full_threshold_o);
    exp_q = '{36'h3C, 36'h2B, 36'hA7, 36'h51, 36'h0, 36'h0};
    read_back("x9");
  endtask
  task automatic test_par18;
    rst_to(1'b0, `FFOP_BUS_X18);
    step(OWR, 36'h1111);
    step(OWR, 36'h3FFFF);
    step(OWR, 36'h2222);
    step(PSE);
    step(OWR, 36'h0);
    step(OWR, 36'h3333);
    step(IDL);
    #1 chk("ae18", 36'h3333, almost_empty_threshold_o);
    chk("af18", 36'h2222, almost_full_threshold_o);
    step(ORD);
    step(IDL);
    partial_rst_i <= 1'b1;
    #1 chk("el18", 36'h3333, output_word_o);
    step(ORD);
    partial_rst_i <= 1'b0;
    step(IDL);
    #1 chk("eh18", 36'h0, output_word_o);
    rst_to(1'b0, `FFOP_BUS_X18);
    exp_q = '{36'h7F, 36'h0, 36'h7F, 36'h0};
    read_back("rst18");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    test_par36();
    test_ser9();
    test_par18();
    print_verdict();
  end
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
endmodule
